// *** nic_ctrl.sv ***
// nested interrupt controller: arbitration, level bits, entry sequencing
// assumes a core that signals instruction ends and pushes context on request
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "nic_params.svh"

// Behaviour
// [RULE1] fourteen fixed vectors, four programmable nesting levels
// [RULE2] level codes 10,01,00,11 mean levels 0..3
// [RULE3] level bits sit at cc bits 5, 3
// [RULE4] vector addresses fixed at top, hardware ordered
// [RULE5] entry waits for current instruction end
// [RULE6] entry pushes pc, x, a and cc
// [RULE7] entry loads level from vector priority
// [RULE8] load vector only after context saved
// [RULE9] return pops cc, restoring previous level
// [RULE10] reset and trap taken even at level 3
// [RULE11] reset and trap set level 3
// [RULE12] four priority registers, pairs, reset ones
// [RULE13] top nibble of last register reads ones
// [RULE14] writing level-0 code keeps old pair
// [RULE15] raised priority of pending own vector re-enters
// [RULE16] core instructions may also write level bits
// [RULE17] wait stops core, forces level code 10
// [RULE18] wait ends on interrupt, branching to handler
// [RULE19] cc resets to 111x1010, level 3
// [RULE20] accept higher level only; ties by vector order
module nic_ctrl
(
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              arst_n,
	// peripheral requests, bit 0 is highest hardware priority
	input  wire logic [13:0]       irqReq,
	// core side
	input  wire logic              instrEnd,
	input  wire nic_pkg::nic_ops_s ops,
	input  wire logic              saveAck,
	output logic                   saveReq,
	output logic [7:0]             savedCc,
	output logic [7:0]             ccOut,
	output logic [15:0]            vecAddr,
	output logic                   vecStrobe,
	output logic                   cpuStop,
	// axi4-lite slave
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	output logic [1:0]             s_axi_bresp,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	input  wire logic [7:0]        s_axi_araddr,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp
);

	// ==========================================
	// level helpers
	function automatic logic [1:0] lvlOf(input nic_pkg::nic_code_t c);
		logic [1:0] l;
		l = 2'h0;
		case (c) // RULE2
			`NIC_CODE_L1: l = 2'h1;
			`NIC_CODE_L2: l = 2'h2;
			`NIC_CODE_L3: l = 2'h3;
			default:      l = 2'h0;
		endcase
		return l;
	endfunction

	function automatic logic [7:0] keepL0(input logic [7:0] oldV, input logic [7:0] newV);
		logic [7:0] r;
		r = newV;
		for (int p = 0; p < 4; p++)
		begin
			if (newV[2*p +: 2] == `NIC_CODE_L0) // RULE14
				r[2*p +: 2] = oldV[2*p +: 2];
		end
		return r;
	endfunction

	nic_pkg::nic_state_s st;
	nic_pkg::nic_state_s next_st;

	logic [1:0]  curLvl;
	logic [1:0]  bestLvl;
	logic [3:0]  best;
	logic        found;
	logic        wrGo;
	logic [1:0]  selLvl;
	nic_pkg::nic_code_t selCode;

	assign curLvl = lvlOf({st.cc[`NIC_LVL_HI], st.cc[`NIC_LVL_LO]}); // RULE3
	assign selCode = st.pri[st.sel[3:2]][{st.sel[1:0], 1'b0} +: 2];
	assign selLvl = lvlOf(selCode);

	// ==========================================
	// arbitration
	// scanning downward lets the lower vector index win a tie
	always_comb
	begin
		logic [1:0] l;
		l = 2'h0;
		found = 1'b0;
		best = 4'h0;
		bestLvl = 2'h0;
		for (int n = `NIC_NUM_VEC - 1; n >= 0; n--) // RULE1
		begin
			l = lvlOf(st.pri[n/4][2*(n%4) +: 2]);
			// own vector re-enters when raised above the running level
			if (irqReq[n] && l > curLvl && (!found || l >= bestLvl)) // RULE20 RULE15
			begin
				found = 1'b1;
				best = 4'(n);
				bestLvl = l;
			end
		end
	end

	assign wrGo = st.awHeld && st.wHeld && !st.bValid;

	// ==========================================
	// next state
	always_comb
	begin
		next_st = st;
		next_st.vecStrobe = 1'b0;
		// register writes, applied before core events so hardware wins
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_st.awHeld = 1'b1;
			next_st.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_st.wHeld = 1'b1;
			next_st.wData = s_axi_wdata[7:0];
			next_st.wLane = s_axi_wstrb[0];
		end
		if (wrGo)
		begin
			next_st.awHeld = 1'b0;
			next_st.wHeld = 1'b0;
			next_st.bValid = 1'b1;
			next_st.bResp = `NIC_RESP_OK;
			if (st.awAddr == `NIC_OFS_CC)
			begin
				if (st.wLane)
					next_st.cc = st.wData | `NIC_CC_FIXED;
			end
			else if (st.awAddr == `NIC_OFS_PRI0)
			begin
				if (st.wLane)
					next_st.pri[0] = keepL0(st.pri[0], st.wData); // RULE12
			end
			else if (st.awAddr == `NIC_OFS_PRI1)
			begin
				if (st.wLane)
					next_st.pri[1] = keepL0(st.pri[1], st.wData);
			end
			else if (st.awAddr == `NIC_OFS_PRI2)
			begin
				if (st.wLane)
					next_st.pri[2] = keepL0(st.pri[2], st.wData);
			end
			else if (st.awAddr == `NIC_OFS_PRI3)
			begin
				if (st.wLane)
					next_st.pri[3] = keepL0(st.pri[3], st.wData) | `NIC_PRI3_RO; // RULE13
			end
			else if (st.awAddr == `NIC_OFS_STAT)
				next_st.bResp = `NIC_RESP_OK;
			else
				next_st.bResp = `NIC_RESP_ERR;
		end
		if (st.bValid && s_axi_bready)
			next_st.bValid = 1'b0;

		// register reads
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_st.rValid = 1'b1;
			next_st.rResp = `NIC_RESP_OK;
			next_st.rData = 32'h0;
			if (s_axi_araddr == `NIC_OFS_CC)
				next_st.rData[7:0] = st.cc;
			else if (s_axi_araddr == `NIC_OFS_PRI0)
				next_st.rData[7:0] = st.pri[0];
			else if (s_axi_araddr == `NIC_OFS_PRI1)
				next_st.rData[7:0] = st.pri[1];
			else if (s_axi_araddr == `NIC_OFS_PRI2)
				next_st.rData[7:0] = st.pri[2];
			else if (s_axi_araddr == `NIC_OFS_PRI3)
				next_st.rData[7:0] = st.pri[3];
			else if (s_axi_araddr == `NIC_OFS_STAT)
				next_st.rData[7:0] = {st.sel, found, st.isTrap,
					st.fsm == nic_pkg::NIC_SAVE, st.fsm == nic_pkg::NIC_SLEEP};
			else
				next_st.rResp = `NIC_RESP_ERR;
		end
		else if (st.rValid && s_axi_rready)
			next_st.rValid = 1'b0;

		// sequencing
		case (st.fsm)
			nic_pkg::NIC_RSTVEC:
			begin
				// first fetch after reset, at level 3
				next_st.vecAddr = `NIC_VEC_RESET; // RULE10 RULE11
				next_st.vecStrobe = 1'b1;
				next_st.fsm = nic_pkg::NIC_RUN;
			end
			nic_pkg::NIC_RUN:
			begin
				if (ops.trap) // RULE10
				begin
					next_st.isTrap = 1'b1;
					next_st.fsm = nic_pkg::NIC_SAVE;
				end
				else if (instrEnd && found) // RULE5
				begin
					next_st.isTrap = 1'b0;
					next_st.sel = best;
					next_st.fsm = nic_pkg::NIC_SAVE;
				end
				else if (ops.waitOp) // RULE17
				begin
					next_st.cc[`NIC_LVL_HI] = 1'b1;
					next_st.cc[`NIC_LVL_LO] = 1'b0;
					next_st.fsm = nic_pkg::NIC_SLEEP;
				end
				else if (ops.return_from_handler || ops.ccLoad) // RULE9 RULE16
					next_st.cc = ops.ccData | `NIC_CC_FIXED;
				else if (ops.maskSet) // RULE16
				begin
					next_st.cc[`NIC_LVL_HI] = 1'b1;
					next_st.cc[`NIC_LVL_LO] = 1'b1;
				end
				else if (ops.maskReset || ops.haltOp) // RULE16
				begin
					next_st.cc[`NIC_LVL_HI] = 1'b1;
					next_st.cc[`NIC_LVL_LO] = 1'b0;
				end
			end
			nic_pkg::NIC_SLEEP:
			begin
				// the core is stopped, so no instruction end is awaited
				if (found) // RULE18
				begin
					next_st.isTrap = 1'b0;
					next_st.sel = best;
					next_st.fsm = nic_pkg::NIC_SAVE;
				end
			end
			nic_pkg::NIC_SAVE:
			begin
				if (saveAck) // RULE6 RULE8
				begin
					next_st.vecStrobe = 1'b1;
					next_st.fsm = nic_pkg::NIC_RUN;
					if (st.isTrap)
					begin
						next_st.vecAddr = `NIC_VEC_TRAP;
						next_st.cc[`NIC_LVL_HI] = 1'b1; // RULE11
						next_st.cc[`NIC_LVL_LO] = 1'b1;
					end
					else
					begin
						next_st.vecAddr = 16'(`NIC_VEC_TOP - {11'h000, st.sel, 1'b0}); // RULE4
						next_st.cc[`NIC_LVL_HI] = selCode[1]; // RULE7
						next_st.cc[`NIC_LVL_LO] = selCode[0];
					end
				end
			end
			default:
				next_st.fsm = nic_pkg::NIC_RUN;
		endcase
	end

	// ==========================================
	// state register
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st <= '0;
			st.fsm <= nic_pkg::NIC_RSTVEC;
			st.cc <= `NIC_CC_RST; // RULE19
			st.pri <= {4{`NIC_PRI_RST}}; // RULE12
			st.vecAddr <= `NIC_VEC_RESET;
		end
		else
			st <= next_st;
	end

	// ==========================================
	// outputs
	assign saveReq = st.fsm == nic_pkg::NIC_SAVE;
	assign savedCc = st.cc;
	assign ccOut = st.cc;
	assign vecAddr = st.vecAddr;
	assign vecStrobe = st.vecStrobe;
	assign cpuStop = st.fsm == nic_pkg::NIC_SLEEP; // RULE17
	assign s_axi_awready = !st.awHeld && !st.bValid;
	assign s_axi_wready = !st.wHeld && !st.bValid;
	assign s_axi_bvalid = st.bValid;
	assign s_axi_bresp = st.bResp;
	assign s_axi_arready = !st.rValid;
	assign s_axi_rvalid = st.rValid;
	assign s_axi_rdata = st.rData;
	assign s_axi_rresp = st.rResp;

	// ==========================================
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	logic [1:0] ccLvlCode;
	assign ccLvlCode = {st.cc[`NIC_LVL_HI], st.cc[`NIC_LVL_LO]};

	trap_entry_a: assert property ( // RULE11
		saveReq && saveAck && st.isTrap |=> vecStrobe && vecAddr == `NIC_VEC_TRAP
			&& ccLvlCode == `NIC_CODE_L3)
		else $error("trap entry address or level wrong");

	entry_level_a: assert property ( // RULE7
		saveReq && saveAck && !st.isTrap |=> vecStrobe && ccLvlCode == $past(selCode))
		else $error("entry level not taken from vector priority");

	sleep_level_a: assert property ( // RULE17
		cpuStop |-> ccLvlCode == `NIC_CODE_L0)
		else $error("wait level not forced to 10");

	save_first_a: assert property ( // RULE8
		vecStrobe && vecAddr != `NIC_VEC_RESET |-> $past(saveReq) && $past(saveAck))
		else $error("vector loaded before context saved");

	accept_higher_a: assert property ( // RULE20
		$rose(saveReq) && !st.isTrap |-> selLvl > $past(curLvl))
		else $error("request accepted without higher level");

	pri3_top_a: assert property ( // RULE13
		st.pri[3][7:4] == 4'hf)
		else $error("top nibble of last priority register lost");

	l0_keep_a: assert property ( // RULE14
		wrGo && st.wLane && st.awAddr == `NIC_OFS_PRI0 && st.wData[1:0] == `NIC_CODE_L0
			|=> st.pri[0][1:0] == $past(st.pri[0][1:0]))
		else $error("level-0 write changed a pair");

	return_from_handler_restore_a: assert property ( // RULE9
		st.fsm == nic_pkg::NIC_RUN && !ops.trap && !(instrEnd && found) && !ops.waitOp
			&& ops.return_from_handler |=> st.cc == ($past(ops.ccData) | `NIC_CC_FIXED))
		else $error("return did not restore cc");

	wake_wait_a: assert property ( // RULE18
		cpuStop && found |=> saveReq)
		else $error("wait not left on interrupt");

	trap_cover_c: cover property (saveReq && saveAck && st.isTrap);
	wake_cover_c: cover property (cpuStop ##1 saveReq);
	nest_cover_c: cover property (vecStrobe && curLvl != 2'h3 ##[1:50] $rose(saveReq));
	l0_cover_c: cover property (wrGo && st.wData[1:0] == `NIC_CODE_L0);

endmodule
`default_nettype wire

// *** nic_params.svh ***
// constants of the nested interrupt controller: offsets, resets, fields
// assumes inclusion by the controller package and module only
`ifndef NIC_PARAMS_SVH
`define NIC_PARAMS_SVH
// ==========================================
// register byte offsets
`define NIC_OFS_CC    8'h00
`define NIC_OFS_PRI0  8'h04
`define NIC_OFS_PRI1  8'h08
`define NIC_OFS_PRI2  8'h0c
`define NIC_OFS_PRI3  8'h10
`define NIC_OFS_STAT  8'h14
// ==========================================
// reset values and fields
`define NIC_CC_RST    8'hea
`define NIC_CC_FIXED  8'hc0
`define NIC_PRI_RST   8'hff
`define NIC_PRI3_RO   8'hf0
`define NIC_LVL_HI    5
`define NIC_LVL_LO    3
// ==========================================
// level codes, high bit then low bit
`define NIC_CODE_L0   2'b10
`define NIC_CODE_L1   2'b01
`define NIC_CODE_L2   2'b00
`define NIC_CODE_L3   2'b11
// ==========================================
// vector addresses
`define NIC_VEC_RESET 16'hfffe
`define NIC_VEC_TRAP  16'hfffc
`define NIC_VEC_TOP   16'hfffa
`define NIC_NUM_VEC   14
// ==========================================
// bus answers
`define NIC_RESP_OK   2'b00
`define NIC_RESP_ERR  2'b10
`endif

// *** nic_pkg.sv ***
// types of the nested interrupt controller
// assumes nic_params.svh is on the include path
`default_nettype none
`include "nic_params.svh"
package nic_pkg;
	typedef logic [1:0] nic_code_t;
	typedef enum logic [1:0] {NIC_RSTVEC, NIC_RUN, NIC_SAVE, NIC_SLEEP} nic_fsm_e;
	// instruction events from the core, one-cycle pulses
	typedef struct packed {
		logic       trap;
		logic       waitOp;
		logic       maskSet;
		logic       maskReset;
		logic       haltOp;
		logic       return_from_handler;
		logic       ccLoad;
		logic [7:0] ccData;
	} nic_ops_s;
	typedef struct packed {
		nic_fsm_e        fsm;
		logic [7:0]      cc;
		logic [3:0][7:0] pri;
		logic            isTrap;
		logic [3:0]      sel;
		logic [15:0]     vecAddr;
		logic            vecStrobe;
		logic            awHeld;
		logic [7:0]      awAddr;
		logic            wHeld;
		logic [7:0]      wData;
		logic            wLane;
		logic            bValid;
		logic [1:0]      bResp;
		logic            rValid;
		logic [31:0]     rData;
		logic [1:0]      rResp;
	} nic_state_s;
endpackage
`default_nettype wire

// *** nic_core_model.sv ***
// core stand-in: acknowledges each context push after a set delay
// assumes the controller holds saveReq until the acknowledge is taken
`timescale 1ns/1ps
`default_nettype none
module nic_core_model
(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       arst_n,
	// push handshake
	input  wire logic       saveReq,
	input  wire logic [3:0] ackDelay,
	output logic            saveAck
);
	logic [3:0] waitCnt;
	// ==========================================
	// push engine
	// a slow push shows whether the vector fetch waits for the stack
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			waitCnt <= 4'h0;
			saveAck <= 1'b0;
		end
		else if (saveReq && !saveAck && waitCnt == ackDelay)
		begin
			saveAck <= 1'b1;
			waitCnt <= 4'h0;
		end
		else
		begin
			saveAck <= 1'b0;
			waitCnt <= (saveReq && !saveAck) ? waitCnt + 4'h1 : 4'h0;
		end
	end
endmodule
`default_nettype wire

// *** nested_interrupt_priority_ctrl_test.sv ***
// testbench of the nested interrupt controller
// assumes a core model that acknowledges pushes, bus driven as axi4-lite master
`timescale 1ns/1ps
`default_nettype none
module nested_interrupt_priority_ctrl_test;
	typedef struct packed
	{
		logic [7:0]  adr;
		logic [31:0] dat;
		logic [31:0] exp;
		logic [1:0]  rsp;
	} nic_row_s;
	logic sys_clk, arst_n, instrEnd, saveAck, saveReq, vecStrobe, cpuStop, sawAck;
	logic [13:0] irqReq;
	logic [7:0] savedCc, ccOut, lastSaved;
	logic [15:0] vecAddr;
	logic [3:0] ackDelay, s_axi_wstrb;
	nic_pkg::nic_ops_s ops, op;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	int errCount, checks;
	nic_row_s rows [7] = '{
		'{8'h04, 32'h55, 32'h55, 2'h0}, '{8'h04, 32'h56, 32'h55, 2'h0},
		'{8'h08, 32'hcf, 32'hcf, 2'h0},
		'{8'h08, 32'h64, 32'h44, 2'h0}, '{8'h10, 32'h00, 32'hf0, 2'h0},
		'{8'h0c, 32'h0f, 32'h0f, 2'h0}, '{8'h18, 32'h5a, 32'h00, 2'h2}};

	nic_ctrl dut (
		.sys_clk(sys_clk), .arst_n(arst_n), .irqReq(irqReq), .instrEnd(instrEnd),
		.ops(ops), .saveAck(saveAck), .saveReq(saveReq), .savedCc(savedCc),
		.ccOut(ccOut), .vecAddr(vecAddr), .vecStrobe(vecStrobe), .cpuStop(cpuStop),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));
	nic_core_model core (.sys_clk(sys_clk), .arst_n(arst_n), .saveReq(saveReq),
		.ackDelay(ackDelay), .saveAck(saveAck));

	// ==========================================
	// shared tasks
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			errCount++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	// address and data are each released at the edge that takes them
	task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
		logic awGo, wGo;
		@(posedge sys_clk);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_bready <= 1'b1;
		do
		begin
			@(negedge sys_clk);
			awGo = s_axi_awvalid && s_axi_awready === 1'b1;
			wGo = s_axi_wvalid && s_axi_wready === 1'b1;
			@(posedge sys_clk);
			if (awGo)
				s_axi_awvalid <= 1'b0;
			if (wGo)
				s_axi_wvalid <= 1'b0;
		end
		while ((s_axi_awvalid && !awGo) || (s_axi_wvalid && !wGo));
		do @(negedge sys_clk); while (s_axi_bvalid !== 1'b1);
		rs = s_axi_bresp;
		@(posedge sys_clk);
		s_axi_bready <= 1'b0;
	endtask

	task automatic axiRd(input logic [7:0] a);
		@(posedge sys_clk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'b1;
		do @(negedge sys_clk); while (s_axi_arready !== 1'b1);
		@(posedge sys_clk);
		s_axi_arvalid <= 1'b0;
		do @(negedge sys_clk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		@(posedge sys_clk);
		s_axi_rready <= 1'b0;
	endtask

	task automatic pulseOp(input nic_pkg::nic_ops_s o);
		@(posedge sys_clk);
		ops <= o;
		@(posedge sys_clk);
		ops <= '0;
		@(negedge sys_clk);
	endtask

	// waits for the fetch strobe, noting the push handshake on the way
	task automatic waitVec(input logic [15:0] adr, input logic [1:0] code);
		sawAck = 1'b0;
		do
		begin
			@(negedge sys_clk);
			if (saveReq === 1'b1)
				lastSaved = savedCc;
			if (saveAck === 1'b1)
				sawAck = 1'b1;
		end
		while (vecStrobe !== 1'b1);
		cmp("vecAddr", adr, vecAddr);
		cmp("level", code, {ccOut[5], ccOut[3]});
	endtask

	task final_report;
		if (errCount == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ==========================================
	// clock, watchdog
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	initial
	begin
		#400000;
		errCount++;
		final_report();
	end

	// ==========================================
	// sequence
	initial
	begin
		{arst_n, instrEnd, irqReq, ops, op, ackDelay, s_axi_awaddr, s_axi_araddr} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hf;
		repeat (5) @(posedge sys_clk);
		arst_n <= 1'b1;
		waitVec(16'hfffe, 2'b11);
		for (int i = 0; i < 5; i++)
		begin
			axiRd(8'(i * 4));
			cmp("reset value", (i == 0) ? 32'hea : 32'hff, rd);
		end
		foreach (rows[i])
		begin
			axiWr(rows[i].adr, rows[i].dat);
			cmp("bresp", rows[i].rsp, rs);
			axiRd(rows[i].adr);
			cmp("rdata", rows[i].exp, rd);
			cmp("rresp", rows[i].rsp, rs);
		end
		// a write with lane 0 off leaves the register alone
		s_axi_wstrb <= 4'he;
		axiWr(8'h0c, 32'h55);
		cmp("bresp", 32'h0, rs);
		s_axi_wstrb <= 4'hf;
		axiRd(8'h0c);
		cmp("rdata", 32'h0f, rd);
		// three equal requests at level 1 while running at level 0: lowest index wins, no nesting at its level
		axiWr(8'h00, 32'he2);
		cmp("ccOut", 32'he2, ccOut);
		@(posedge sys_clk);
		irqReq <= 14'h000e;
		instrEnd <= 1'b1;
		waitVec(16'hfff8, 2'b01);
		cmp("savedCc", 32'he2, lastSaved);
		repeat (4)
		begin
			@(negedge sys_clk);
			cmp("saveReq", 32'h0, saveReq);
		end
		@(posedge sys_clk);
		irqReq <= '0;
		op = '0;
		op.return_from_handler = 1'b1;
		op.ccData = lastSaved;
		pulseOp(op);
		cmp("ccOut", 32'he2, ccOut);
		// trap at level 3 with a slow push
		ackDelay <= 4'h5;
		op = '0;
		op.maskSet = 1'b1;
		pulseOp(op);
		cmp("level", 32'h3, {ccOut[5], ccOut[3]});
		op = '0;
		op.trap = 1'b1;
		pulseOp(op);
		waitVec(16'hfffc, 2'b11);
		cmp("push first", 32'h1, sawAck);
		// wait mode and wake-up without an instruction end
		@(posedge sys_clk);
		instrEnd <= 1'b0;
		op = '0;
		op.waitOp = 1'b1;
		pulseOp(op);
		cmp("cpuStop", 32'h1, cpuStop);
		cmp("level", 32'h2, {ccOut[5], ccOut[3]});
		// status: last vector 1, nothing found, trap seen, not saving, asleep
		axiRd(8'h14);
		cmp("status", 32'h15, rd);
		@(posedge sys_clk);
		irqReq <= 14'h0001;
		waitVec(16'hfffa, 2'b01);
		cmp("cpuStop", 32'h0, cpuStop);
		// raise the running vector while still pending: re-entry waits for an instruction end
		axiWr(8'h04, 32'h54);
		cmp("bresp", 32'h0, rs);
		repeat (3)
		begin
			@(negedge sys_clk);
			cmp("saveReq", 32'h0, saveReq);
		end
		@(posedge sys_clk);
		instrEnd <= 1'b1;
		waitVec(16'hfffa, 2'b00);
		// reset in mid-run, with a request still pending
		@(posedge sys_clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b1;
		waitVec(16'hfffe, 2'b11);
		axiRd(8'h00);
		cmp("reset value", 32'hea, rd);
		axiRd(8'h04);
		cmp("reset value", 32'hff, rd);
		cmp("saveReq", 32'h0, saveReq);
		final_report();
	end
endmodule
`default_nettype wire
